// file: rtl/lti_defs.vh
// Register map, field positions, reset values and timing for the lux threshold block
`ifndef LTI_DEFS_VH
`define LTI_DEFS_VH

// Register offsets
`define LTI_ADDR_STATUS     8'h00
`define LTI_ADDR_ENABLE     8'h01
`define LTI_ADDR_CONFIG     8'h02
`define LTI_ADDR_LUX_HIGH   8'h03
`define LTI_ADDR_LUX_LOW    8'h04
`define LTI_ADDR_HIGH_TRIP  8'h05
`define LTI_ADDR_LOW_TRIP   8'h06
`define LTI_ADDR_PERSIST    8'h07

// Field positions
`define LTI_STATUS_BIT      0
`define LTI_ENABLE_BIT      0
`define LTI_CFG_MANUAL_BIT  6
`define LTI_CFG_CDR_BIT     3
`define LTI_CFG_TIM_MSB     2
`define LTI_CFG_TIM_LSB     0

// Reset values
`define LTI_RST_ENABLE      1'b0
`define LTI_RST_MANUAL      1'b0
`define LTI_RST_CDR         1'b0
`define LTI_RST_TIM         3'h0
`define LTI_RST_HIGH_TRIP   8'hff
`define LTI_RST_LOW_TRIP    8'h00
`define LTI_RST_PERSIST     8'hff

// Exponent codes
`define LTI_EXP_OVERLOAD    4'hf

// Integration time codes
`define LTI_TIM_800MS       3'h0
`define LTI_TIM_400MS       3'h1
`define LTI_TIM_200MS       3'h2
`define LTI_TIM_100MS       3'h3

// Auto ranging limits, in result counts of 0.045 lux
`define LTI_CDR_LUX         700
`define LTI_LSB_MILLILUX    45
`define LTI_CDR_COUNTS      ((`LTI_CDR_LUX * 1000) / `LTI_LSB_MILLILUX)
`define LTI_TIM100_COUNTS   23'h0_0800
`define LTI_TIM200_COUNTS   23'h0_0400
`define LTI_TIM400_COUNTS   23'h0_0200

// Timing
`define LTI_CLK_HZ          20000000
`define LTI_STEP_MS         100
`define LTI_STEP_CYCLES     ((`LTI_CLK_HZ / 1000) * `LTI_STEP_MS)
`define LTI_STEP_CNT_W      21

`endif

// file: rtl/lti_step_timer.v
// Restartable divider giving one enable pulse per persistence step
`default_nettype none
`include "lti_defs.vh"

module lti_step_timer #(
    parameter CYCLES = `LTI_STEP_CYCLES, // Clock cycles per step
    parameter CNT_W  = `LTI_STEP_CNT_W   // Counter width
) (
    input  wire core_clk, // System clock
    input  wire rstn,     // Asynchronous reset, active low
    input  wire restart,  // Holds the count at zero
    output reg  tick      // One-cycle pulse at each full step
);

    localparam integer     LAST_I = CYCLES - 1;
    localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

    reg [CNT_W-1:0] count;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (restart) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (count == LAST) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: rtl/lti_threshold_irq.v
// Lux window comparator with persistence timer, status flag, result and auto ranging
`default_nettype none
`include "lti_defs.vh"
// Contract
// - Low trip level register: exponent in bits 7:4, mantissa top nibble below.
// - High trip level register uses the same exponent over mantissa nibble layout.
// - Enabled and light under low trip beyond persistence: set flag, pull pin low.
// - Enabled and light outside either trip beyond persistence: flag to 1, pin low.
// - Persistence delay equals the unsigned timer register value times 100 ms.
// - Timer value zero asserts the interrupt as soon as a trip level is crossed.
// - Threshold interrupts work only while enable register bit 0 is one.
// - Interrupt pin is open drain, active low, pulled low while a flag is pending.
// - Reading status or writing enable to zero clears the status flag.
// - Light is a four-bit exponent and eight-bit mantissa, lux = 2^e * m * 0.045.
// - Valid exponents reach 14; exponent code 15 marks an overload reading.
// - The 12-bit result is split over the lux high and lux low registers.
// - Auto ranging sets divide and time itself, dividing by 8 above 700 lux.
// - Auto ranging lengthens integration 100, 200, 400, 800 ms as light falls.
// - Manual mode lets software set the divide bit and three-bit time field.
// - Low trip mantissa reads with low nibble zero, range 0 to 240.
// - High trip mantissa reads with low nibble ones, range 15 to 255.

module lti_threshold_irq #(
    parameter STEP_CYCLES = `LTI_STEP_CYCLES, // Clock cycles in one 100 ms step
    parameter STEP_CNT_W  = `LTI_STEP_CNT_W   // Width of the step divider counter
) (
    input  wire       core_clk,              // System clock, 20 MHz
    input  wire       rstn,                  // Asynchronous reset, active low
    input  wire [7:0] reg_addr,              // Register offset from the serial slave
    input  wire [7:0] reg_wdata,             // Write data
    input  wire       reg_wr,                // Write strobe, one cycle
    input  wire       reg_rd,                // Read strobe, one cycle
    input  wire       reg_hold,              // High from address phase until stop
    output reg  [7:0] reg_rdata,             // Read data, valid the cycle after reg_rd
    input  wire       meas_valid,            // New converter result, one cycle
    input  wire [3:0] meas_exponent,         // Result exponent
    input  wire [7:0] meas_mantissa,         // Result mantissa
    output reg        current_divide_select, // Photodiode current divide by 8
    output reg  [2:0] integration_time_sel,  // Integration time code
    output wire       irq_pin_o,             // Interrupt pin drive level
    output wire       irq_pin_oe,            // Interrupt pin pull-down enable
    output reg        irq_status_flag        // Pending interrupt status
);

    // Linear count of an exponent and mantissa pair
    function [22:0] lin_value;
        input [3:0] exponent;
        input [7:0] mantissa;
        begin
            lin_value = {15'h0000, mantissa} << exponent;
        end
    endfunction

    // Register state
    reg       irq_enable_bit;
    reg       manual_mode;
    reg       man_cdr;
    reg [2:0] man_tim;
    reg       auto_cdr;
    reg [2:0] auto_tim;
    reg [7:0] lux_high;
    reg [7:0] lux_low;
    reg [7:0] high_trip_level;
    reg [7:0] low_trip_level;
    reg [7:0] trip_persistence_time;

    // Comparator and persistence state
    reg       above_high;
    reg       below_low;
    reg [8:0] step_count;

    wire       step_tick;
    wire [3:0] high_trip_exponent;
    wire [3:0] high_trip_mantissa_hi;
    wire [3:0] low_trip_exponent;
    wire [3:0] low_trip_mantissa_hi;
    wire [22:0] meas_lin;
    wire [22:0] high_lin;
    wire [22:0] low_lin;
    wire        overload;
    wire        outside;
    wire        fire;
    wire        restart;
    wire        status_read;
    wire        enable_off;
    wire        next_status;

    assign high_trip_exponent    = high_trip_level[7:4];
    assign high_trip_mantissa_hi = high_trip_level[3:0];
    assign low_trip_exponent     = low_trip_level[7:4];
    assign low_trip_mantissa_hi  = low_trip_level[3:0];

    assign meas_lin = lin_value(meas_exponent, meas_mantissa);
    assign high_lin = lin_value(high_trip_exponent, {high_trip_mantissa_hi, 4'hf});
    assign low_lin  = lin_value(low_trip_exponent, {low_trip_mantissa_hi, 4'h0});
    assign overload = (meas_exponent == `LTI_EXP_OVERLOAD);

    // Window comparison, refreshed on every converter result
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            above_high <= 1'b0;
            below_low  <= 1'b0;
        end else if (meas_valid) begin
            if (overload) begin
                above_high <= 1'b1;
                below_low  <= 1'b0;
            end else begin
                above_high <= (meas_lin > high_lin);
                below_low  <= (meas_lin < low_lin);
            end
        end
    end

    assign outside = above_high | below_low;

    // Persistence: count whole steps of an unbroken excursion
    assign restart = ~outside | ~irq_enable_bit | fire;

    lti_step_timer #(
        .CYCLES (STEP_CYCLES),
        .CNT_W  (STEP_CNT_W)
    ) u_step_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .restart  (restart),
        .tick     (step_tick)
    );

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            step_count <= 9'h000;
        end else if (restart) begin
            step_count <= 9'h000;
        end else if (step_tick && (step_count != 9'h1ff)) begin
            step_count <= step_count + 9'h001;
        end
    end

    // Zero timer fires on the first outside cycle, others after the full delay
    assign fire = irq_enable_bit & outside &
                  ((trip_persistence_time == 8'h00) |
                   (step_count >= {1'b0, trip_persistence_time}));

    // Status flag: set beats clear so no excursion is lost
    assign status_read = reg_rd && (reg_addr == `LTI_ADDR_STATUS);
    assign enable_off  = reg_wr && (reg_addr == `LTI_ADDR_ENABLE) &&
                         !reg_wdata[`LTI_ENABLE_BIT];
    assign next_status = fire ? 1'b1 :
                         (status_read | enable_off) ? 1'b0 :
                         irq_status_flag;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_flag <= 1'b0;
        end else begin
            irq_status_flag <= next_status;
        end
    end

    // Open drain: only ever drives low
    assign irq_pin_o  = 1'b0;
    assign irq_pin_oe = irq_status_flag;

    // Host writable registers
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_enable_bit        <= `LTI_RST_ENABLE;
            manual_mode           <= `LTI_RST_MANUAL;
            man_cdr               <= `LTI_RST_CDR;
            man_tim               <= `LTI_RST_TIM;
            high_trip_level       <= `LTI_RST_HIGH_TRIP;
            low_trip_level        <= `LTI_RST_LOW_TRIP;
            trip_persistence_time <= `LTI_RST_PERSIST;
        end else if (reg_wr) begin
            case (reg_addr)
                `LTI_ADDR_ENABLE: begin
                    irq_enable_bit <= reg_wdata[`LTI_ENABLE_BIT];
                end
                `LTI_ADDR_CONFIG: begin
                    manual_mode <= reg_wdata[`LTI_CFG_MANUAL_BIT];
                    // Range bits are written only by a config write that also sets the manual bit
                    if (reg_wdata[`LTI_CFG_MANUAL_BIT]) begin
                        man_cdr <= reg_wdata[`LTI_CFG_CDR_BIT];
                        man_tim <= reg_wdata[`LTI_CFG_TIM_MSB:`LTI_CFG_TIM_LSB];
                    end
                end
                `LTI_ADDR_HIGH_TRIP: begin
                    high_trip_level <= reg_wdata;
                end
                `LTI_ADDR_LOW_TRIP: begin
                    low_trip_level <= reg_wdata;
                end
                `LTI_ADDR_PERSIST: begin
                    trip_persistence_time <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Result registers; frozen during a host transfer so both bytes match
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lux_high <= 8'h00;
            lux_low  <= 8'h00;
        end else if (meas_valid && !reg_hold) begin
            lux_high <= {meas_exponent, meas_mantissa[7:4]};
            lux_low  <= {4'h0, meas_mantissa[3:0]};
        end
    end

    // Auto ranging from the lux-referred count of each result
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            auto_cdr <= 1'b0;
            auto_tim <= `LTI_TIM_100MS;
        end else if (meas_valid) begin
            if (overload) begin
                auto_cdr <= 1'b1;
                auto_tim <= `LTI_TIM_100MS;
            end else begin
                auto_cdr <= (meas_lin > `LTI_CDR_COUNTS);
                if (meas_lin >= `LTI_TIM100_COUNTS) begin
                    auto_tim <= `LTI_TIM_100MS;
                end else if (meas_lin >= `LTI_TIM200_COUNTS) begin
                    auto_tim <= `LTI_TIM_200MS;
                end else if (meas_lin >= `LTI_TIM400_COUNTS) begin
                    auto_tim <= `LTI_TIM_400MS;
                end else begin
                    auto_tim <= `LTI_TIM_800MS;
                end
            end
        end
    end

    // Range settings driven to the converter
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            current_divide_select <= 1'b0;
            integration_time_sel  <= `LTI_TIM_100MS;
        end else if (manual_mode) begin
            current_divide_select <= man_cdr;
            integration_time_sel  <= man_tim;
        end else begin
            current_divide_select <= auto_cdr;
            integration_time_sel  <= auto_tim;
        end
    end

    // Read port; status returns its value before the clear
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LTI_ADDR_STATUS:    reg_rdata <= {7'h00, irq_status_flag};
                `LTI_ADDR_ENABLE:    reg_rdata <= {7'h00, irq_enable_bit};
                `LTI_ADDR_CONFIG:    reg_rdata <= {1'b0, manual_mode, 2'b00,
                                                   current_divide_select,
                                                   integration_time_sel};
                `LTI_ADDR_LUX_HIGH:  reg_rdata <= lux_high;
                `LTI_ADDR_LUX_LOW:   reg_rdata <= lux_low;
                `LTI_ADDR_HIGH_TRIP: reg_rdata <= high_trip_level;
                `LTI_ADDR_LOW_TRIP:  reg_rdata <= low_trip_level;
                `LTI_ADDR_PERSIST:   reg_rdata <= trip_persistence_time;
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: verif/lti_checker.sv
// Port assertions for the lux threshold interrupt block
`default_nettype none
module lti_checker #(
    parameter STEP_CYCLES = 20, // Clock cycles per step
    parameter STEP_CNT_W  = 8   // Step counter width
) (
    input wire logic       core_clk,              // Clock
    input wire logic       rstn,                  // Reset, active low
    input wire logic [7:0] reg_addr,              // Offset
    input wire logic [7:0] reg_wdata,             // Write data
    input wire logic       reg_wr,                // Write strobe
    input wire logic       reg_rd,                // Read strobe
    input wire logic       reg_hold,              // Result freeze
    input wire logic [7:0] reg_rdata,             // Read data
    input wire logic       meas_valid,            // New result
    input wire logic [3:0] meas_exponent,         // Exponent
    input wire logic [7:0] meas_mantissa,         // Mantissa
    input wire logic       current_divide_select, // Divide by 8
    input wire logic [2:0] integration_time_sel,  // Time code
    input wire logic       irq_pin_o,             // Pin level
    input wire logic       irq_pin_oe,            // Pin pull-down
    input wire logic       irq_status_flag        // Status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       en_sh;
    logic       man_sh;
    logic [7:0] tmr_sh;
    logic [7:0] lux_sh;
    // Shadows of host writes and of the lux high result, so rules can be tied to state the ports do not show
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_sh  <= 1'b0;
            man_sh <= 1'b0;
            tmr_sh <= 8'hff;
            lux_sh <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == 8'h01) en_sh <= reg_wdata[0];
            if (reg_wr && reg_addr == 8'h02) man_sh <= reg_wdata[6];
            if (reg_wr && reg_addr == 8'h07) tmr_sh <= reg_wdata;
            if (meas_valid && !reg_hold) lux_sh <= {meas_exponent, meas_mantissa[7:4]};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_rd(a);
        (reg_wr && reg_addr == a) ##2 (reg_rd && reg_addr == a);
    endsequence
    sequence s_overload;
        meas_valid && meas_exponent == 4'hf;
    endsequence
    property p_rw(a);
        s_wr_rd(a) |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_pin_low_only: assert property (irq_pin_o == 1'b0)
        else $error("interrupt pin drive level not low");
    a_pin_follows_flag: assert property (irq_pin_oe == irq_status_flag)
        else $error("interrupt pin enable differs from status");
    a_low_trip_rw: assert property (p_rw(8'h06))
        else $error("low trip readback wrong");
    a_high_trip_rw: assert property (p_rw(8'h05))
        else $error("high trip readback wrong");
    a_timer_rw: assert property (p_rw(8'h07))
        else $error("persistence timer readback wrong");
    a_status_read: assert property (reg_rd && reg_addr == 8'h00 |=>
        reg_rdata == {7'h0, $past(irq_status_flag)})
        else $error("status read data wrong");
    a_irq_needs_enable: assert property (!en_sh |-> !$rose(irq_status_flag))
        else $error("status set while disabled");
    a_zero_timer_fire: assert property ((en_sh && tmr_sh == 8'h00) and s_overload |->
        ##2 irq_status_flag)
        else $error("no immediate interrupt with zero timer");
    a_overload_range: assert property ((!man_sh) and s_overload |->
        ##2 current_divide_select && integration_time_sel == 3'h3)
        else $error("overload ranging wrong");
    a_dim_range: assert property (!man_sh && meas_valid && meas_exponent == 4'h0 |->
        ##2 integration_time_sel == 3'h0 && !current_divide_select)
        else $error("dim light ranging wrong");
    a_manual_set: assert property (reg_wr && reg_addr == 8'h02 && reg_wdata[6] |->
        ##2 integration_time_sel == $past(reg_wdata[2:0], 2)
        && current_divide_select == $past(reg_wdata[3], 2))
        else $error("manual range setting not applied");
    a_lux_high: assert property (reg_rd && reg_addr == 8'h03 |=>
        reg_rdata == $past(lux_sh))
        else $error("lux high byte wrong");
endmodule
bind lti_threshold_irq lti_checker #(.STEP_CYCLES(STEP_CYCLES), .STEP_CNT_W(STEP_CNT_W)) chk (
    .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_hold, .reg_rdata,
    .meas_valid, .meas_exponent, .meas_mantissa, .current_divide_select,
    .integration_time_sel, .irq_pin_o, .irq_pin_oe, .irq_status_flag);
`default_nettype wire

// file: verif/lti_host_model.sv
// Host controller model driving the register port of the light sensor block
`default_nettype none
module lti_host_model (
    input  wire logic       core_clk,  // System clock
    output var  logic [7:0] reg_addr,  // Offset
    output var  logic [7:0] reg_wdata, // Write data
    output var  logic       reg_wr,    // Write strobe
    output var  logic       reg_rd,    // Read strobe
    output var  logic       reg_hold   // Result freeze
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_hold  = 1'b0;
    end
    // Idle lines are inverted, so stale values never look like a valid request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
    // Nonzero exponents always carry the top mantissa bit
    task automatic set_trip(input logic [7:0] a, input logic [3:0] e, input logic [3:0] m);
        wr(a, {e, (e != 4'h0) | m[3], m[2:0]});
    endtask
    task automatic hold_set(input logic h);
        @(negedge core_clk);
        reg_hold = h;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the lux threshold interrupt block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 20;
    logic       core_clk;
    logic       rstn;
    wire  [7:0] reg_addr;
    wire  [7:0] reg_wdata;
    wire        reg_wr;
    wire        reg_rd;
    wire        reg_hold;
    wire  [7:0] reg_rdata;
    logic       meas_valid;
    logic [3:0] meas_exponent;
    logic [7:0] meas_mantissa;
    wire        current_divide_select;
    wire  [2:0] integration_time_sel;
    wire        irq_pin_o;
    wire        irq_pin_oe;
    wire        irq_status_flag;
    logic       rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    string      name_q[$];
    int         err_total = 0;
    int         check_count = 0;
    logic [7:0] r;
    logic [3:0] e;
    logic [7:0] ra[5] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'h08};
    logic [7:0] rv[5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    lti_host_model host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_hold);
    lti_threshold_irq #(.STEP_CYCLES(STEP), .STEP_CNT_W(8)) uut (
        .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_hold, .reg_rdata,
        .meas_valid, .meas_exponent, .meas_mantissa, .current_divide_select,
        .integration_time_sel, .irq_pin_o, .irq_pin_oe, .irq_status_flag);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    // Read data lands one edge after the strobe; compare against the oldest note
    always @(posedge core_clk) rd_pend <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0) begin
            chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
        end
    end
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        name_q.push_back(n);
        host.rd(a);
    endtask
    task automatic meas(input logic [3:0] ex, input logic [7:0] m);
        @(negedge core_clk);
        meas_valid    = 1'b1;
        meas_exponent = ex;
        meas_mantissa = m;
        @(negedge core_clk);
        meas_valid = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic flag_for(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            if (irq_status_flag !== v) break;
        end
        chk("irq_status_flag", {7'h0, v}, {7'h0, irq_status_flag});
    endtask
    task automatic wait_flag(input int n);
        for (int i = 0; i < n && irq_status_flag !== 1'b1; i++) @(negedge core_clk);
        if (irq_status_flag !== 1'b1) begin
            chk("irq wait", 8'h01, {7'h0, irq_status_flag});
            end_of_test();
        end else begin
            chk("irq_pin_oe", 8'h01, {7'h0, irq_pin_oe});
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        meas_valid = 1'b0;
        meas_exponent = 4'h0;
        meas_mantissa = 8'h00;
        void'($urandom(32'h6c6c));
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        foreach (ra[i]) rd_chk("reset value", ra[i], rv[i]);
        host.wr(8'h08, 8'h5a);
        rd_chk("unmapped", 8'h08, 8'h00);
        for (int a = 5; a < 8; a++) begin
            r = {4'($urandom_range(14, 1)), 1'b1, 3'($urandom)};
            host.wr(8'(a), r);
            rd_chk("readback", 8'(a), r);
        end
        for (int i = 0; i < 3; i++) begin
            e = 4'($urandom_range(14));
            r = 8'($urandom);
            meas(e, r);
            rd_chk("lux high", 8'h03, {e, r[7:4]});
            rd_chk("lux low", 8'h04, {4'h0, r[3:0]});
        end
        host.hold_set(1'b1);
        meas(4'h2, ~r);
        rd_chk("lux held", 8'h03, {e, r[7:4]});
        host.hold_set(1'b0);
        for (int t = 0; t < 8; t++) begin
            host.wr(8'h02, {2'b01, 2'b00, 1'(t), 3'(t)});
            repeat (2) @(negedge core_clk);
            chk("time code", 8'(t % 8), {5'h0, integration_time_sel});
            chk("divide", 8'(t % 2), {7'h0, current_divide_select});
        end
        rd_chk("config", 8'h02, 8'h4f);
        host.wr(8'h02, 8'h00);
        for (int x = 0; x < 5; x++) begin
            meas(4'(x), 8'h80);
            chk("auto time", (x < 2) ? 8'h00 : 8'(x - 1), {5'h0, integration_time_sel});
        end
        meas(4'h6, 8'hf3);
        chk("auto divide", 8'h00, {7'h0, current_divide_select});
        meas(4'h6, 8'hf4);
        chk("auto divide", 8'h01, {7'h0, current_divide_select});
        host.set_trip(8'h05, 4'h1, 4'h9);
        host.set_trip(8'h06, 4'h1, 4'h8);
        host.wr(8'h07, 8'h00);
        // Settle inside the window first, a stale excursion would fire on enable
        meas(4'h1, 8'h9f);
        host.wr(8'h01, 8'h01);
        flag_for(1'b0, 4);
        meas(4'h1, 8'ha0);
        wait_flag(4);
        meas(4'h1, 8'h90);
        rd_chk("status", 8'h00, 8'h01);
        flag_for(1'b0, 3);
        meas(4'h1, 8'h80);
        flag_for(1'b0, 4);
        meas(4'h1, 8'h7f);
        wait_flag(4);
        meas(4'h1, 8'h90);
        host.wr(8'h01, 8'h00);
        flag_for(1'b0, 3);
        meas(4'h1, 8'h7f);
        flag_for(1'b0, 6);
        meas(4'h1, 8'h90);
        host.set_trip(8'h05, 4'he, 4'hf);
        host.wr(8'h01, 8'h01);
        meas(4'he, 8'hff);
        flag_for(1'b0, 4);
        meas(4'hf, 8'h12);
        wait_flag(4);
        rd_chk("overload", 8'h03, 8'hf1);
        meas(4'h1, 8'h90);
        rd_chk("status", 8'h00, 8'h01);
        host.wr(8'h07, 8'h03);
        // High trip now sits at the top, so excursions go below the low trip
        meas(4'h1, 8'h7f);
        flag_for(1'b0, STEP * 2);
        meas(4'h1, 8'h90);
        meas(4'h1, 8'h7f);
        flag_for(1'b0, STEP * 3 - 8);
        wait_flag(16);
        repeat (3) @(negedge core_clk);
        end_of_test();
    end
endmodule
`default_nettype wire
